// >>> rtl/scf_pkg.sv
// Purpose: shared constants and types for the smart card format control block
// Assumes: 32-bit apb, byte addresses, one register per aligned word
// Notes:   offsets other than the format register layout are local choices
package scf_pkg;

  // register byte addresses
  localparam logic [7:0] A_FMT  = 8'h00;
  localparam logic [7:0] A_MODE = 8'h04;
  localparam logic [7:0] A_TXD  = 8'h08;
  localparam logic [7:0] A_RXD  = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;

  // format register fields
  localparam int         FMT_MODE = 0;
  localparam int         FMT_INV  = 2;
  localparam int         FMT_DIR  = 3;
  localparam logic [7:0] FMT_ONES = 8'hF2;

  // serial mode register fields
  localparam int MODE_SEVEN = 0;
  localparam int MODE_ODD   = 1;

  // status register fields
  localparam int ST_RXF  = 0;
  localparam int ST_PERR = 1;
  localparam int ST_CNT  = 2;

  // transmit buffer depth
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef struct packed {
    logic dir;
    logic inv;
    logic mode;
  } scf_fmt_type;

  localparam scf_fmt_type FMT_RST = 3'h0;

  typedef struct packed {
    logic [7:0] data;
    logic       parity;
  } scf_char_type;

  localparam scf_char_type CHAR_RST = 9'h000;

endpackage

// >>> rtl/scf_format_ctrl.sv
// Purpose: apb register file, bit order and inversion formatting for a smart card serial channel
// Assumes: serial engine on pclk, shifts tx_char.data lsb first and hands rx data as seen on the line
// Notes:   tx words are formatted when written, so the buffer output feeds the engine directly
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps

module scf_format_ctrl
  import scf_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  output scf_pkg::scf_char_type       tx_char,
  output logic                        tx_valid,
  input  wire logic                   tx_ready,
  input  wire scf_pkg::scf_char_type  rx_char,
  input  wire logic                   rx_valid,
  output logic                        rx_ready,
  output logic                        card_mode,
  output logic                        char_seven,
  output logic                        parity_odd
);
  import scf_pkg::*;

  scf_fmt_type  fmt_q,     fmt_d;
  logic         seven_q,   seven_d;
  logic         odd_q,     odd_d;
  scf_char_type buf_q [2];
  scf_char_type buf_d [2];
  logic [1:0]   cnt_q,     cnt_d;
  logic         txv_q,     txv_d;
  logic [7:0]   rhr_q,     rhr_d;
  logic         rxf_q,     rxf_d;
  logic         perr_q,    perr_d;
  logic         rxr_q,     rxr_d;
  logic         rdy_q,     rdy_d;
  logic         err_q,     err_d;
  logic [31:0]  rdat_q,    rdat_d;

  logic         acc;
  logic         done;
  logic         hit;
  logic         wr_txd;
  logic         push;
  logic         pop;
  logic         rx_take;
  logic [7:0]   tx_fmt;
  logic         tx_par;
  logic [7:0]   rx_fmt;
  logic         rx_par;

  // bit order and inversion; both are self-inverse, so one function serves both paths
  function automatic logic [7:0] fmt_conv(input logic [7:0] d, input logic seven, input scf_fmt_type f);
    logic [7:0] r;
    r = d;
    if (seven) begin
      r = {1'b0, d[6:0] ^ {7{f.inv}}};
    end else begin
      if (f.dir) begin
        for (int i = 0; i < 8; i++) begin
          r[i] = d[7-i];
        end
      end
      r = r ^ {8{f.inv}};
    end
    return r;
  endfunction

  // parity over the plain data, so inversion never moves it
  function automatic logic par_of(input logic [7:0] d, input logic seven, input logic odd);
    logic p;
    p = seven ? ^d[6:0] : ^d;
    return p ^ odd;
  endfunction

  assign acc     = psel & penable & ~rdy_q;
  assign done    = psel & penable & rdy_q;
  assign wr_txd  = pwrite & (paddr == A_TXD);
  assign push    = done & wr_txd;
  assign pop     = txv_q & tx_ready;
  assign rx_take = rx_valid & rxr_q;
  assign tx_fmt  = fmt_conv(pwdata[7:0], seven_q, fmt_q);
  assign tx_par  = par_of(pwdata[7:0], seven_q, odd_q);
  assign rx_fmt  = fmt_conv(rx_char.data, seven_q, fmt_q);
  assign rx_par  = par_of(rx_fmt, seven_q, odd_q);

  always_comb begin
    hit = 1'b0;
    unique case (paddr)
      A_FMT, A_MODE, A_RXD, A_STAT: hit = ~pwrite | (paddr != A_RXD);
      A_TXD: hit = pwrite;
      default: hit = 1'b0;
    endcase
  end

  always_comb begin
    fmt_d   = fmt_q;
    seven_d = seven_q;
    odd_d   = odd_q;
    buf_d   = buf_q;
    cnt_d   = cnt_q;
    rhr_d   = rhr_q;
    rxf_d   = rxf_q;
    perr_d  = perr_q;
    rdat_d  = rdat_q;
    err_d   = 1'b0;
    // a full buffer holds the write in its access phase until the engine drains a word
    rdy_d   = acc & ~(wr_txd & (cnt_q == BUF_DEPTH));
    if (acc) begin
      err_d  = ~hit;
      rdat_d = 32'h0000_0000;
      unique case (paddr)
        A_FMT: begin
          rdat_d[7:0] = FMT_ONES;
          rdat_d[FMT_DIR]  = fmt_q.dir;
          rdat_d[FMT_INV]  = fmt_q.inv;
          rdat_d[FMT_MODE] = fmt_q.mode;
        end
        A_MODE: begin
          rdat_d[MODE_SEVEN] = seven_q;
          rdat_d[MODE_ODD]   = odd_q;
        end
        A_RXD: rdat_d[7:0] = rhr_q;
        A_STAT: begin
          rdat_d[ST_RXF]            = rxf_q;
          rdat_d[ST_PERR]           = perr_q;
          rdat_d[ST_CNT+1:ST_CNT]   = cnt_q;
        end
        default: rdat_d = 32'h0000_0000;
      endcase
    end
    if (done & pwrite) begin
      unique case (paddr)
        A_FMT: begin
          fmt_d.dir  = pwdata[FMT_DIR];
          fmt_d.inv  = pwdata[FMT_INV];
          fmt_d.mode = pwdata[FMT_MODE];
        end
        A_MODE: begin
          seven_d = pwdata[MODE_SEVEN];
          odd_d   = pwdata[MODE_ODD];
        end
        A_STAT: begin
          if (pwdata[ST_PERR]) begin
            perr_d = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    // transmit buffer: entry 0 is the head seen by the engine
    if (pop) begin
      buf_d[0] = buf_q[1];
      cnt_d    = cnt_q - 2'h1;
    end
    if (push) begin
      if (cnt_d == 2'h0) begin
        buf_d[0] = '{data: tx_fmt, parity: tx_par};
      end else begin
        buf_d[1] = '{data: tx_fmt, parity: tx_par};
      end
      cnt_d = cnt_d + 2'h1;
    end
    // receive: a read empties the holding register, a new word in the same cycle wins
    if (done & ~pwrite & (paddr == A_RXD)) begin
      rxf_d = 1'b0;
    end
    if (rx_take) begin
      rhr_d = rx_fmt;
      rxf_d = 1'b1;
      if (rx_par != rx_char.parity) begin
        perr_d = 1'b1;
      end
    end
    txv_d = cnt_d != 2'h0;
    rxr_d = ~rxf_d;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmt_q   <= FMT_RST;
      seven_q <= 1'b0;
      odd_q   <= 1'b0;
      buf_q   <= '{CHAR_RST, CHAR_RST};
      cnt_q   <= 2'h0;
      txv_q   <= 1'b0;
      rhr_q   <= 8'h00;
      rxf_q   <= 1'b0;
      perr_q  <= 1'b0;
      rxr_q   <= 1'b1;
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      rdat_q  <= 32'h0000_0000;
    end else begin
      fmt_q   <= fmt_d;
      seven_q <= seven_d;
      odd_q   <= odd_d;
      buf_q   <= buf_d;
      cnt_q   <= cnt_d;
      txv_q   <= txv_d;
      rhr_q   <= rhr_d;
      rxf_q   <= rxf_d;
      perr_q  <= perr_d;
      rxr_q   <= rxr_d;
      rdy_q   <= rdy_d;
      err_q   <= err_d;
      rdat_q  <= rdat_d;
    end
  end

  assign prdata     = rdat_q;
  assign pready     = rdy_q;
  assign pslverr    = err_q;
  assign tx_char    = buf_q[0];
  assign tx_valid   = txv_q;
  assign rx_ready   = rxr_q;
  assign card_mode  = fmt_q.mode;
  assign char_seven = seven_q;
  assign parity_odd = odd_q;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_rsvd_high;
    done & ~pwrite & (paddr == A_FMT) |-> (prdata[7:4] == 4'hF) && (prdata[31:8] == 24'h00_0000);
  endproperty
  a_rsvd_high: assert property (p_rsvd_high) else $error("format bits 7:4 not read as 1");

  property p_bit1_high;
    done & ~pwrite & (paddr == A_FMT) |-> prdata[1];
  endproperty
  a_bit1_high: assert property (p_bit1_high) else $error("format bit 1 not read as 1");

  property p_msb_first;
    push & ~seven_q & fmt_q.dir & ~fmt_q.inv |-> tx_fmt == {<<{pwdata[7:0]}};
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("msb first order wrong");

  property p_seven_lsb;
    push & seven_q |-> tx_fmt == {1'b0, pwdata[6:0] ^ {7{fmt_q.inv}}};
  endproperty
  a_seven_lsb: assert property (p_seven_lsb) else $error("7-bit data not lsb first");

  property p_par_plain;
    push |-> tx_par == (seven_q ? ^pwdata[6:0] : ^pwdata[7:0]) ^ odd_q;
  endproperty
  a_par_plain: assert property (p_par_plain) else $error("parity follows inversion");

  property p_plain_pass;
    push & (cnt_q == 2'h0) & ~pop & ~seven_q & ~fmt_q.dir & ~fmt_q.inv |=> tx_char.data == $past(pwdata[7:0]);
  endproperty
  a_plain_pass: assert property (p_plain_pass) else $error("plain data altered");

  property p_rx_inv;
    rx_take & fmt_q.inv & ~fmt_q.dir & ~seven_q |=> rxf_q && (rhr_q == ~$past(rx_char.data));
  endproperty
  a_rx_inv: assert property (p_rx_inv) else $error("receive data not inverted");

  property p_mode_sel;
    done & pwrite & (paddr == A_FMT) |=> card_mode == $past(pwdata[FMT_MODE]);
  endproperty
  a_mode_sel: assert property (p_mode_sel) else $error("mode select not taken");

  property p_fmt_rw;
    done & ~pwrite & (paddr == A_FMT) |-> prdata[3:0] == {fmt_q.dir, fmt_q.inv, 1'b1, fmt_q.mode};
  endproperty
  a_fmt_rw: assert property (p_fmt_rw) else $error("format fields not readable");

  property p_tx_inv;
    push & (cnt_q == 2'h0) & ~seven_q & ~fmt_q.dir & fmt_q.inv |=> tx_char.data == ~$past(pwdata[7:0]);
  endproperty
  a_tx_inv: assert property (p_tx_inv) else $error("transmit data not inverted");

  property p_rx_plain;
    rx_take & ~fmt_q.inv & ~fmt_q.dir & ~seven_q |=> rxf_q && (rhr_q == $past(rx_char.data));
  endproperty
  a_rx_plain: assert property (p_rx_plain) else $error("receive data altered");

  property p_rx_seven;
    rx_take & seven_q |=> !rhr_q[7] && (rhr_q[6:0] == ($past(rx_char.data[6:0]) ^ {7{$past(fmt_q.inv)}}));
  endproperty
  a_rx_seven: assert property (p_rx_seven) else $error("7-bit receive data not lsb first");

endmodule

// >>> tb/scf_card_model.sv
// Purpose: serial engine and card side model, takes tx words and hands rx words
// Assumes: pclk domain, valid/ready handshake on both streams
// Notes:   stall holds off tx so the bench can fill the buffer
`timescale 1ns/1ps

module scf_card_model
  import scf_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire scf_pkg::scf_char_type tx_char,
  input  wire logic                  tx_valid,
  output logic                       tx_ready,
  output scf_pkg::scf_char_type      rx_char,
  output logic                       rx_valid,
  input  wire logic                  rx_ready,
  input  wire logic                  stall
);
  import scf_pkg::*;
  scf_char_type got;
  int           got_n;

  assign tx_ready = presetn && !stall;

  initial begin
    rx_valid = 1'b0;
    rx_char  = CHAR_RST;
    got_n    = 0;
  end

  always @(posedge pclk) begin
    if (tx_valid && tx_ready) begin
      got   <= tx_char;
      got_n <= got_n + 1;
    end
  end

  // held until taken; afterwards the lines show the inverse, not a stale word
  task automatic send(input scf_char_type c);
    rx_char  <= c;
    rx_valid <= 1'b1;
    do @(posedge pclk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    rx_char  <= ~c;
  endtask
endmodule

// >>> tb/tb.sv
// Purpose: self-checking bench for the smart card format control block
// Assumes: apb master on pclk, card model on the stream side
// Notes:   expected words come from the bench's own format function
`timescale 1ns/1ps

module tb;
  import scf_pkg::*;
  logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic         tx_valid, tx_ready, rx_valid, rx_ready, stall;
  logic         card_mode, char_seven, parity_odd;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rd;
  scf_char_type tx_char, rx_char;
  int           failures, n_checks, cyc;

  scf_format_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_char(tx_char),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_char(rx_char), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .card_mode(card_mode), .char_seven(char_seven), .parity_odd(parity_odd));
  scf_card_model i_card (.pclk(pclk), .presetn(presetn), .tx_char(tx_char), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_char(rx_char), .rx_valid(rx_valid), .rx_ready(rx_ready), .stall(stall));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never re-drives psel in the same time step
    @(posedge pclk);
  endtask

  // m: bit3 order, bit2 invert, bit1 odd parity, bit0 seven bits
  function automatic logic [8:0] fmt(input logic [7:0] d, input logic [3:0] m);
    logic [7:0] r;
    logic       p;
    r = m[0] ? {1'b0, d[6:0]} : d;
    p = ^r ^ m[1];
    if (!m[0] && m[3]) r = {<<{r}};
    if (m[2]) r = r ^ (m[0] ? 8'h7F : 8'hFF);
    return {r, p};
  endfunction

  task automatic t_reset();
    apb(0, A_FMT, 0);
    chk(rd, 32'h0000_00F2);
    chk(card_mode, 0);
  endtask

  task automatic t_fmt();
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = 8'hF2 | {4'h0, i[2], i[1], 1'b0, i[0]};
      apb(1, A_FMT, {24'h0, v});
      apb(0, A_FMT, 0);
      chk(rd, {24'h0, v});
      chk(card_mode, i[0]);
    end
  endtask

  task automatic t_stream();
    logic [7:0] d;
    logic [8:0] e;
    int         n;
    for (int i = 0; i < 16; i++) begin
      d = 8'hC5 ^ {4'h0, i[3:0]};
      apb(1, A_MODE, {30'h0, i[1:0]});
      apb(1, A_FMT, {24'h0, 8'hF3 | {4'h0, i[3], i[2], 2'h0}});
      n = i_card.got_n;
      apb(1, A_TXD, {24'h0, d});
      for (int k = 0; k < 20 && i_card.got_n == n; k++) @(posedge pclk);
      e = fmt(d, i[3:0]);
      chk(i_card.got, e);
      chk({char_seven, parity_odd}, {i[0], i[1]});
      i_card.send(e);
      @(posedge pclk);
      chk(rx_ready, 0);
      apb(0, A_RXD, 0);
      chk(rd, {24'h0, i[0] ? {1'b0, d[6:0]} : d});
      chk(rx_ready, 1);
      apb(0, A_STAT, 0);
      chk(rd[1:0], 0);
    end
  endtask

  task automatic t_buf();
    int n;
    apb(1, A_MODE, 0);
    apb(1, A_FMT, 32'h0000_00F2);
    stall <= 1'b1;
    n = i_card.got_n;
    apb(1, A_TXD, 32'h0000_0011);
    apb(1, A_TXD, 32'h0000_0022);
    apb(0, A_STAT, 0);
    chk(rd[3:2], 2);
    fork
      apb(1, A_TXD, 32'h0000_0033);
      begin
        repeat (6) @(posedge pclk);
        chk(tx_char, fmt(8'h11, 0));
        chk(tx_valid, 1);
        chk(pready, 0);
        stall <= 1'b0;
      end
    join
    for (int k = 0; k < 20 && i_card.got_n != n + 3; k++) @(posedge pclk);
    chk(i_card.got_n - n, 3);
    chk(i_card.got, fmt(8'h33, 0));
    apb(0, 8'h14, 0);
    chk(err, 1);
    chk(rd, 0);
  endtask

  // reset in mid-run must bring the written fields back to their reset values
  task automatic t_rst2();
    apb(1, A_FMT, 32'h0000_00FF);
    apb(1, A_MODE, 32'h0000_0003);
    chk(card_mode, 1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({card_mode, char_seven, parity_odd, tx_valid, rx_ready}, 5'b00001);
    apb(0, A_FMT, 0);
    chk(rd, 32'h0000_00F2);
  endtask

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  // a hang ends the run through the same report
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, stall} = '0;
    paddr = '0;
    pwdata = '0;
    {failures, n_checks, cyc} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_fmt();
    t_stream();
    t_buf();
    t_rst2();
    final_report();
  end
endmodule
